// [core/slocfg_pkg.sv]
// package: register map, field layout and carriers of the lane config block
package slocfg_pkg;
  localparam int unsigned NUM_LANES    = 8;
  localparam int unsigned LANE_W       = 8;
  localparam int unsigned ADR_W        = 16;
  localparam int unsigned IDX_W        = 14;
  localparam int unsigned SWING_W      = 3;
  localparam int unsigned REG_W        = 8;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_POL_INV = 14'h05bf;
  localparam logic [IDX_W-1:0] IDX_SWING_A = 14'h05c0;
  localparam logic [IDX_W-1:0] IDX_SWING_B = 14'h05c1;
  localparam logic [IDX_W-1:0] IDX_SWING_C = 14'h05c2;
  localparam logic [IDX_W-1:0] IDX_SWING_D = 14'h05c3;
  localparam int unsigned IDX_LSB      = 2;
  // swing register fields
  localparam int unsigned SW_LO_LSB    = 0;
  localparam int unsigned SW_HI_LSB    = 4;
  localparam logic [SWING_W-1:0] SWING_RST   = 3'h1;
  localparam logic [SWING_W-1:0] SWING_FULL  = 3'h0;
  localparam logic [SWING_W-1:0] SWING_P850  = 3'h1;
  localparam logic [SWING_W-1:0] SWING_P750  = 3'h2;
  localparam logic               INV_RST     = 1'h0;

  typedef logic [SWING_W-1:0] slocfg_swing_t;

  typedef struct packed {
    logic          invert;
    slocfg_swing_t swing;
  } slocfg_lane_cfg_t;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [3:0]        sel;
    logic [ADR_W-1:0]  adr;
    logic [31:0]       dat;
  } slocfg_wb_req_t;
endpackage

// [core/slocfg_lane.sv]
// one lane: stored swing code, polarity bit and registered lane word
`timescale 1ns/1ns
module slocfg_lane
  import slocfg_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              swing_we_i,
  input  wire slocfg_swing_t     swing_d_i,
  input  wire logic              inv_we_i,
  input  wire logic              inv_d_i,
  input  wire logic [LANE_W-1:0] word_i,
  output slocfg_lane_cfg_t       cfg_o,
  output logic [LANE_W-1:0]      word_o
);
  slocfg_swing_t swing_r;
  logic          inv_r;
  logic [LANE_W-1:0] word_nxt;

  assign word_nxt = inv_r ? ~word_i : word_i;
  assign cfg_o    = '{invert: inv_r, swing: swing_r};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      swing_r <= SWING_RST;
      inv_r   <= INV_RST;
      word_o  <= '0;
    end else begin
      if (swing_we_i) begin
        swing_r <= swing_d_i;
      end
      if (inv_we_i) begin
        inv_r <= inv_d_i;
      end
      word_o <= word_nxt;
    end
  end
endmodule

// [core/slocfg_top.sv]
// serial lane output config: wishbone register bank, per-lane swing/invert
//
// Operation
// - index 0x05c0 holds lane 1 swing in bits 6:4 and lane 0 in 2:0, r/w.
// - index 0x05c1 holds lane 3 swing in bits 6:4 and lane 2 in 2:0, r/w.
// - index 0x05c2 holds lane 5 swing in bits 6:4 and lane 4 in 2:0, r/w.
// - index 0x05c3 holds lane 7 swing in bits 6:4, r/w.
// - index 0x05c3 holds lane 6 swing in bits 2:0, r/w, same reset value.
// - codes 000, 001, 010 pick full, 0.850 and 0.750 of driver supply.
// - every swing field leaves reset holding 0x1.
`timescale 1ns/1ns
module slocfg_top
  import slocfg_pkg::*;
(
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  input  wire logic                          we_i,
  input  wire logic [3:0]                    sel_i,
  input  wire logic [ADR_W-1:0]              adr_i,
  input  wire logic [31:0]                   dat_i,
  output logic [31:0]                        dat_o,
  output logic                               ack_o,
  input  wire logic [NUM_LANES-1:0][LANE_W-1:0] lane_word_i,
  output logic [NUM_LANES-1:0][LANE_W-1:0]   serial_lane_out_o,
  output slocfg_lane_cfg_t [NUM_LANES-1:0]   lane_cfg_o
);
  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  slocfg_wb_req_t   req;
  logic             ack_r;
  logic [31:0]      dat_r;
  logic [31:0]      rd_nxt;
  logic [IDX_W-1:0] idx;
  logic             wr_lo;
  logic             hit_pol;
  logic [3:0]       hit_sw;
  logic [REG_W-1:0] pol_rd;
  logic [3:0][REG_W-1:0] sw_rd;
  logic [REG_W-1:0] rd_byte;

  assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i,
                 adr: adr_i, dat: dat_i};
  assign idx       = req.adr[ADR_W-1:IDX_LSB];
  // a single access per request: write fires on the ack edge only
  assign wr_lo     = req.cyc & req.stb & req.we & req.sel[0] & ~ack_r;
  assign hit_pol   = (idx == IDX_POL_INV);
  assign hit_sw[0] = (idx == IDX_SWING_A);
  assign hit_sw[1] = (idx == IDX_SWING_B);
  assign hit_sw[2] = (idx == IDX_SWING_C);
  assign hit_sw[3] = (idx == IDX_SWING_D);

  // ----------------------------------------------------------------------
  // write strobes and field select
  // ----------------------------------------------------------------------
  // two lanes share each swing register: the even lane sits in the low
  // field, the odd lane in the high field
  logic [NUM_LANES-1:0] sw_we;
  logic                 inv_we;
  slocfg_swing_t        sw_lo_d;
  slocfg_swing_t        sw_hi_d;
  logic [REG_W-1:0]     pol_d;

  assign inv_we   = wr_lo & hit_pol;
  assign pol_d    = req.dat[REG_W-1:0];
  assign sw_lo_d  = req.dat[SW_LO_LSB +: SWING_W];
  assign sw_hi_d  = req.dat[SW_HI_LSB +: SWING_W];
  assign sw_we[0] = wr_lo & hit_sw[0];
  assign sw_we[1] = wr_lo & hit_sw[0];
  assign sw_we[2] = wr_lo & hit_sw[1];
  assign sw_we[3] = wr_lo & hit_sw[1];
  assign sw_we[4] = wr_lo & hit_sw[2];
  assign sw_we[5] = wr_lo & hit_sw[2];
  assign sw_we[6] = wr_lo & hit_sw[3];
  assign sw_we[7] = wr_lo & hit_sw[3];

  // ----------------------------------------------------------------------
  // lanes
  // ----------------------------------------------------------------------
  // one instance per lane keeps each lane's stored state in one place;
  // the polarity strobe is shared, each lane takes its own data bit
  // lane 0: low field of register a, polarity bit 0
  slocfg_lane u_lane0 (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .swing_we_i (sw_we[0]),
    .swing_d_i  (sw_lo_d),
    .inv_we_i   (inv_we),
    .inv_d_i    (pol_d[0]),
    .word_i     (lane_word_i[0]),
    .cfg_o      (lane_cfg_o[0]),
    .word_o     (serial_lane_out_o[0])
  );

  // lane 1: high field of register a, polarity bit 1
  slocfg_lane u_lane1 (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .swing_we_i (sw_we[1]),
    .swing_d_i  (sw_hi_d),
    .inv_we_i   (inv_we),
    .inv_d_i    (pol_d[1]),
    .word_i     (lane_word_i[1]),
    .cfg_o      (lane_cfg_o[1]),
    .word_o     (serial_lane_out_o[1])
  );

  // lane 2: low field of register b, polarity bit 2
  slocfg_lane u_lane2 (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .swing_we_i (sw_we[2]),
    .swing_d_i  (sw_lo_d),
    .inv_we_i   (inv_we),
    .inv_d_i    (pol_d[2]),
    .word_i     (lane_word_i[2]),
    .cfg_o      (lane_cfg_o[2]),
    .word_o     (serial_lane_out_o[2])
  );

  // lane 3: high field of register b, polarity bit 3
  slocfg_lane u_lane3 (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .swing_we_i (sw_we[3]),
    .swing_d_i  (sw_hi_d),
    .inv_we_i   (inv_we),
    .inv_d_i    (pol_d[3]),
    .word_i     (lane_word_i[3]),
    .cfg_o      (lane_cfg_o[3]),
    .word_o     (serial_lane_out_o[3])
  );

  // lane 4: low field of register c, polarity bit 4
  slocfg_lane u_lane4 (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .swing_we_i (sw_we[4]),
    .swing_d_i  (sw_lo_d),
    .inv_we_i   (inv_we),
    .inv_d_i    (pol_d[4]),
    .word_i     (lane_word_i[4]),
    .cfg_o      (lane_cfg_o[4]),
    .word_o     (serial_lane_out_o[4])
  );

  // lane 5: high field of register c, polarity bit 5
  slocfg_lane u_lane5 (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .swing_we_i (sw_we[5]),
    .swing_d_i  (sw_hi_d),
    .inv_we_i   (inv_we),
    .inv_d_i    (pol_d[5]),
    .word_i     (lane_word_i[5]),
    .cfg_o      (lane_cfg_o[5]),
    .word_o     (serial_lane_out_o[5])
  );

  // lane 6: low field of register d, polarity bit 6
  slocfg_lane u_lane6 (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .swing_we_i (sw_we[6]),
    .swing_d_i  (sw_lo_d),
    .inv_we_i   (inv_we),
    .inv_d_i    (pol_d[6]),
    .word_i     (lane_word_i[6]),
    .cfg_o      (lane_cfg_o[6]),
    .word_o     (serial_lane_out_o[6])
  );

  // lane 7: high field of register d, polarity bit 7
  slocfg_lane u_lane7 (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .swing_we_i (sw_we[7]),
    .swing_d_i  (sw_hi_d),
    .inv_we_i   (inv_we),
    .inv_d_i    (pol_d[7]),
    .word_i     (lane_word_i[7]),
    .cfg_o      (lane_cfg_o[7]),
    .word_o     (serial_lane_out_o[7])
  );

  // ----------------------------------------------------------------------
  // read words
  // ----------------------------------------------------------------------
  assign pol_rd = {lane_cfg_o[7].invert, lane_cfg_o[6].invert,
                   lane_cfg_o[5].invert, lane_cfg_o[4].invert,
                   lane_cfg_o[3].invert, lane_cfg_o[2].invert,
                   lane_cfg_o[1].invert, lane_cfg_o[0].invert};
  // reserved bits 7 and 3 are never stored and read zero
  assign sw_rd[0] = {1'b0, lane_cfg_o[1].swing,
                     1'b0, lane_cfg_o[0].swing};
  assign sw_rd[1] = {1'b0, lane_cfg_o[3].swing,
                     1'b0, lane_cfg_o[2].swing};
  assign sw_rd[2] = {1'b0, lane_cfg_o[5].swing,
                     1'b0, lane_cfg_o[4].swing};
  assign sw_rd[3] = {1'b0, lane_cfg_o[7].swing,
                     1'b0, lane_cfg_o[6].swing};

  // ----------------------------------------------------------------------
  // read mux and ack
  // ----------------------------------------------------------------------
  assign rd_byte = hit_pol   ? pol_rd   :
                   hit_sw[0] ? sw_rd[0] :
                   hit_sw[1] ? sw_rd[1] :
                   hit_sw[2] ? sw_rd[2] :
                   hit_sw[3] ? sw_rd[3] : '0;
  // unmapped addresses still ack, reading zero, so the master never hangs
  assign rd_nxt = {{(32-REG_W){1'b0}}, rd_byte};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= req.cyc & req.stb & ~ack_r;
      dat_r <= rd_nxt;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;
endmodule

// [verif/slocfg_asserts.sv]
// checker: bus timing, field map and lane path of the config block
`timescale 1ns/1ns
module slocfg_asserts
  import slocfg_pkg::*;
(
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire logic                         cyc_i,
  input wire logic                         stb_i,
  input wire logic                         we_i,
  input wire logic [3:0]                   sel_i,
  input wire logic [ADR_W-1:0]             adr_i,
  input wire logic [31:0]                  dat_i,
  input wire logic [31:0]                  dat_o,
  input wire logic                         ack_o,
  input wire logic [7:0][LANE_W-1:0]       lane_word_i,
  input wire logic [7:0][LANE_W-1:0]       serial_lane_out_o,
  input wire slocfg_lane_cfg_t [7:0]       lane_cfg_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic             rd = ack_o && !we_i;
  wire logic             go = cyc_i && stb_i && !ack_o;
  wire logic [IDX_W-1:0] ix = adr_i[15:2];
  ack_once_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_lat_a: assert property (go |=> ack_o)
    else $error("ack missing");
  wr_code_a: assert property (go && we_i && sel_i[0] && ix == IDX_SWING_A
    |=> lane_cfg_o[0].swing == $past(dat_i[2:0])) else $error("code lost");
  lane_inv_a: assert property (!$past(rst_i) |-> serial_lane_out_o[0] ==
    ($past(lane_word_i[0]) ^ {8{$past(lane_cfg_o[0].invert)}}))
    else $error("lane word wrong");
  rsv_zero_a: assert property (rd && ix[13:2] == 12'h170
    |-> dat_o[31:7] == 0 && !dat_o[3]) else $error("reserved set");
  rd_lo_a: assert property (rd && ix == IDX_SWING_A |-> dat_o[6:0] ==
    {lane_cfg_o[1].swing, 1'b0, lane_cfg_o[0].swing}) else $error("rd a");
  rd_hi_a: assert property (rd && ix == IDX_SWING_D |-> dat_o[6:0] ==
    {lane_cfg_o[7].swing, 1'b0, lane_cfg_o[6].swing}) else $error("rd d");
  rst_val_a: assert property ($fell(rst_i) |-> lane_cfg_o[6].swing ==
    SWING_RST && !lane_cfg_o[0].invert) else $error("reset value");
  cover property (rd && ix == IDX_POL_INV);
  cover property (go && we_i && ix == IDX_SWING_D);
  cover property ($fell(rst_i));
endmodule

// [verif/slocfg_rx_model.sv]
// far-side model: lane word source and the word sent one cycle back
`timescale 1ns/1ns
module slocfg_rx_model
  import slocfg_pkg::*;
(
  input  wire logic                  clk_i,
  output logic [7:0][LANE_W-1:0]     word_o,
  output logic [7:0][LANE_W-1:0]     prev_o
);
  // odd step so every bit of every lane keeps toggling
  initial word_o = '0;
  always @(posedge clk_i) begin
    word_o <= word_o + 64'h0123456789abcdef;
    prev_o <= word_o;
  end
endmodule

// [verif/serial_lane_output_config_tb.sv]
// bench: register access, reset values, codes and lane inversion
`timescale 1ns/1ns
`define CHK(n,e,a) begin cmp_count++; if ((a) !== (e)) begin \
  $display("[FAIL] %s exp %h got %h", n, e, a); miscompares++; end end
module serial_lane_output_config_tb;
  import slocfg_pkg::*;
  slocfg_wb_req_t           req = '0;
  wire logic                cyc_i = req.cyc, stb_i = req.stb, we_i = req.we;
  wire logic [3:0]          sel_i = req.sel;
  wire logic [ADR_W-1:0]    adr_i = req.adr;
  wire logic [31:0]         dat_i = req.dat;
  logic                     clk_i = 0, rst_i = 1, ack_o;
  logic [31:0]              dat_o;
  logic [7:0][LANE_W-1:0]   lane_word_i, serial_lane_out_o, prev;
  slocfg_lane_cfg_t [7:0]   lane_cfg_o;
  logic [3:0]               sl = 4'h1;
  logic [7:0]               q;
  int                       miscompares = 0, cmp_count = 0;
  slocfg_top slocfg_top_inst (.*);
  slocfg_rx_model slocfg_rx_model_inst (.clk_i(clk_i), .word_o(lane_word_i),
    .prev_o(prev));
  initial forever #20 clk_i = ~clk_i;
  // ----------------------------------------
  // bus and end-of-test tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [13:0] ix, logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, sl, {ix, 2'b00}, {24'h0, d}};
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 9);
    if (ack_o !== 1'b1) begin
      $display("[FAIL] ack exp 1 got %b", ack_o);
      miscompares++;
      end_of_test();
    end else begin
      q = dat_o[7:0];
      req <= '0;
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    `CHK("cfg rst", {8{4'h1}}, lane_cfg_o)
    for (int i = 0; i < 4; i++) begin
      xfer(0, IDX_SWING_A + 14'(i), 0);
      `CHK("swing rst", 8'h11, q)
      xfer(1, IDX_SWING_A + 14'(i), 8'haa);
      xfer(0, IDX_SWING_A + 14'(i), 0);
      `CHK("swing rsv", 8'h22, q)
    end
    for (logic [2:0] c = 0; c < 3; c++) begin
      xfer(1, IDX_SWING_D, {1'b0, c, 1'b0, c});
      `CHK("code", {c, c}, {lane_cfg_o[7].swing, lane_cfg_o[6].swing})
    end
    sl = 4'h0;
    xfer(1, IDX_SWING_A, 8'h11);
    sl = 4'h1;
    xfer(0, IDX_SWING_A, 0);
    `CHK("no sel", 8'h22, q)
    xfer(0, 14'h0100, 0);
    `CHK("unmapped", 8'h00, q)
    xfer(1, IDX_POL_INV, 8'h05);
    xfer(0, IDX_POL_INV, 0);
    `CHK("pol", 8'h05, q)
    // lanes 2 and 0 inverted: the xor with the sent word is all ones there
    @(posedge clk_i);
    `CHK("lane", 64'h00ff00ff, serial_lane_out_o ^ prev)
    // mid-run reset must bring back every default over written values
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    `CHK("cfg rst2", {8{4'h1}}, lane_cfg_o)
    xfer(0, IDX_SWING_D, 0);
    `CHK("swing rst2", 8'h11, q)
    xfer(0, IDX_POL_INV, 0);
    `CHK("pol rst", 8'h00, q)
    end_of_test();
  end
endmodule
bind slocfg_top slocfg_asserts slocfg_asserts_inst (.*);
